// ---- core/rlc_link_coder.sv ----
// Function
// - separate clock and data wire per direction
// - two input and two output link wires
// - timing from clock wire, no recovery
// - regenerate clock and data downstream
// - sample data at clock rising edge
// - fixed nibble to five-bit symbol table
// - idle, special, reset, set, termination codes
// - J then K marks frame start
// - NRZI: one toggles, zero holds
// - never more than three zeros in row outside a forced reset
// - long held one distributes ring reset
`timescale 1ns/1ps
`default_nettype none
`include "rlc_map.svh"

module rlc_link_coder
    import rlc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic ring_clk_in,
    input wire logic ring_dat_in,
    output logic ring_clk_out,
    output logic ring_dat_out,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic tx_force_rst,
    output logic [7:0] rx_byte,
    output logic rx_byte_vld,
    output logic rx_sof,
    output logic rx_eof,
    output logic rx_ctrl,
    output logic [4:0] rx_ctrl_sym,
    output logic rx_code_err,
    output logic ring_rst_out
);

    localparam logic [79:0] DATA_TAB = `RLC_DATA_TABLE;
    localparam logic [11:0] RST_HOLD = 12'(`RLC_RST_HOLD_CYC);

    function automatic logic [4:0] rlc_enc(input logic [3:0] n);
        rlc_enc = DATA_TAB[n*5 +: 5];
    endfunction : rlc_enc

    // ****************************************
    // pin synchronisers and clock edges
    // ****************************************
    logic [1:0] pin_s;
    logic clk_s;
    logic dat_s;
    logic clk_prev;
    logic clk_rise;
    logic clk_fall;

    rlc_sync #(.W(2)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .d_async({ring_clk_in, ring_dat_in}),
        .d_sync(pin_s)
    );

    assign clk_s = pin_s[1];
    assign dat_s = pin_s[0];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            clk_prev <= 1'b0;
        end else if (ce) begin
            clk_prev <= clk_s;
        end
    end

    // timing comes only from the clock wire
    assign clk_rise = clk_s & ~clk_prev;
    assign clk_fall = ~clk_s & clk_prev;

    // ****************************************
    // transmit buffer
    // ****************************************
    rlc_strm_if #(.W(8)) u_in_if ();
    rlc_strm_if #(.W(8)) u_out_if ();
    logic fifo_pop;
    logic [3:0] fifo_hi;

    assign u_in_if.data = tx_data;
    assign u_in_if.valid = tx_valid;
    assign tx_ready = u_in_if.ready;
    assign u_out_if.ready = fifo_pop;
    assign fifo_hi = u_out_if.data[7:4];

    rlc_fifo #(.WIDTH(`RLC_BYTE_W), .DEPTH(`RLC_FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .wr(u_in_if),
        .rd(u_out_if)
    );

    // ****************************************
    // transmit symbol sequencing
    // ****************************************
    rlc_tx_state_t tx_state;
    rlc_tx_state_t next_tx_state;
    logic [4:0] tx_sym;
    logic [4:0] next_tx_sym;
    logic [2:0] tx_idx;
    logic [7:0] tx_byte;
    logic tx_bit;
    logic tx_sym_end;
    logic tx_force;
    logic [2:0] tx_zrun;

    assign tx_bit = tx_sym[3'd4 - tx_idx];
    assign tx_sym_end = clk_fall & (tx_idx == 3'd4);
    assign tx_force = tx_force_rst | ring_rst_out;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_sym = `RLC_SYM_IDLE;
        fifo_pop = 1'b0;
        case (tx_state)
            RLC_TX_IDLE: begin
                if (u_out_if.valid) begin
                    next_tx_state = RLC_TX_J;
                    next_tx_sym = `RLC_SYM_J;
                end
            end
            RLC_TX_J: begin
                next_tx_state = RLC_TX_K;
                next_tx_sym = `RLC_SYM_K;
            end
            RLC_TX_K, RLC_TX_LO: begin
                if (u_out_if.valid) begin
                    next_tx_state = RLC_TX_HI;
                    next_tx_sym = rlc_enc(fifo_hi);
                    fifo_pop = tx_sym_end;
                end else begin
                    next_tx_state = RLC_TX_TERM;
                    next_tx_sym = `RLC_SYM_T;
                end
            end
            RLC_TX_HI: begin
                next_tx_state = RLC_TX_LO;
                next_tx_sym = rlc_enc(tx_byte[3:0]);
            end
            RLC_TX_TERM: begin
                next_tx_state = RLC_TX_IDLE;
                next_tx_sym = `RLC_SYM_IDLE;
            end
            default: begin
                next_tx_state = RLC_TX_IDLE;
            end
        endcase
    end

    // symbols change only on the outgoing clock's falling edge
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_state <= RLC_TX_IDLE;
            tx_sym <= `RLC_SYM_IDLE;
            tx_idx <= 3'd0;
        end else if (ce && clk_fall) begin
            if (tx_idx == 3'd4) begin
                tx_idx <= 3'd0;
                tx_sym <= next_tx_sym;
                tx_state <= next_tx_state;
            end else begin
                tx_idx <= tx_idx + 3'd1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_byte <= 8'h00;
        end else if (ce && fifo_pop && u_out_if.valid) begin
            tx_byte <= u_out_if.data;
        end
    end

    // ****************************************
    // regenerated link outputs
    // ****************************************
    // data moves as the clock falls, so it is steady at the next rise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ring_clk_out <= 1'b0;
        end else if (ce) begin
            ring_clk_out <= clk_s;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ring_dat_out <= 1'b0;
        end else if (ce) begin
            if (tx_force) begin
                ring_dat_out <= 1'b1;
            end else if (clk_fall) begin
                ring_dat_out <= ring_dat_out ^ tx_bit;
            end
        end
    end

    // zero run seen on the wire, checked below
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_zrun <= 3'd0;
        end else if (ce && (tx_force || (clk_fall && tx_bit))) begin
            tx_zrun <= 3'd0;
        end else if (ce && clk_fall && tx_zrun != 3'd7) begin
            tx_zrun <= tx_zrun + 3'd1;
        end
    end

    // ****************************************
    // receive: NRZI decode and alignment
    // ****************************************
    rlc_rx_state_t rx_state;
    rlc_sym_kind_t rx_kind;
    logic dat_prev;
    logic rx_bit;
    logic [9:0] rx_win;
    logic [9:0] rx_cur;
    logic [4:0] rx_sym;
    logic [2:0] rx_cnt;
    logic rx_half;
    logic [3:0] rx_hi;
    logic [3:0] rx_nib;
    logic [15:0] rx_hit;
    logic rx_sym_end;
    logic rx_sof_hit;

    assign rx_bit = dat_s ^ dat_prev;
    assign rx_cur = {rx_win[8:0], rx_bit};
    assign rx_sym = rx_cur[4:0];
    assign rx_sym_end = clk_rise & (rx_state == RLC_RX_FRAME) & (rx_cnt == 3'd4);
    assign rx_sof_hit = clk_rise & (rx_state == RLC_RX_HUNT) & (rx_cur == `RLC_SOF_PAIR);

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_dec
            assign rx_hit[g] = (rx_sym == DATA_TAB[g*5 +: 5]);
        end
    endgenerate

    always_comb begin
        rx_nib = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (rx_hit[i]) begin
                rx_nib = 4'(i);
            end
        end
        if (|rx_hit) begin
            rx_kind = RLC_SK_DATA;
        end else begin
            case (rx_sym)
                `RLC_SYM_T: rx_kind = RLC_SK_TERM;
                `RLC_SYM_IDLE, `RLC_SYM_H, `RLC_SYM_R, `RLC_SYM_S,
                `RLC_SYM_J, `RLC_SYM_K: rx_kind = RLC_SK_CTRL;
                default: rx_kind = RLC_SK_BAD;
            endcase
        end
    end

    // relies on the far end keeping data steady around the rise
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dat_prev <= 1'b0;
            rx_win <= 10'h000;
        end else if (ce && clk_rise) begin
            dat_prev <= dat_s;
            rx_win <= rx_cur;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_state <= RLC_RX_HUNT;
            rx_cnt <= 3'd0;
            rx_half <= 1'b0;
            rx_hi <= 4'h0;
        end else if (ce && clk_rise) begin
            case (rx_state)
                RLC_RX_HUNT: begin
                    if (rx_sof_hit) begin
                        rx_state <= RLC_RX_FRAME;
                        rx_cnt <= 3'd0;
                        rx_half <= 1'b0;
                    end
                end
                RLC_RX_FRAME: begin
                    if (rx_cnt == 3'd4) begin
                        rx_cnt <= 3'd0;
                        if (rx_kind == RLC_SK_DATA) begin
                            rx_half <= ~rx_half;
                            if (!rx_half) begin
                                rx_hi <= rx_nib;
                            end
                        end else if (rx_kind == RLC_SK_TERM || rx_kind == RLC_SK_BAD) begin
                            rx_state <= RLC_RX_HUNT;
                        end
                    end else begin
                        rx_cnt <= rx_cnt + 3'd1;
                    end
                end
                default: begin
                    rx_state <= RLC_RX_HUNT;
                end
            endcase
        end
    end

    // ****************************************
    // receive outputs
    // ****************************************
    // a nibble left odd at the end of a frame is dropped
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_sof <= 1'b0;
            rx_eof <= 1'b0;
            rx_ctrl <= 1'b0;
            rx_code_err <= 1'b0;
            rx_byte_vld <= 1'b0;
        end else if (ce) begin
            rx_sof <= rx_sof_hit;
            rx_eof <= rx_sym_end & (rx_kind == RLC_SK_TERM);
            rx_ctrl <= rx_sym_end & (rx_kind == RLC_SK_CTRL);
            rx_code_err <= rx_sym_end & (rx_kind == RLC_SK_BAD);
            rx_byte_vld <= rx_sym_end & (rx_kind == RLC_SK_DATA) & rx_half;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_byte <= 8'h00;
            rx_ctrl_sym <= 5'h00;
        end else if (ce && rx_sym_end) begin
            if (rx_kind == RLC_SK_DATA && rx_half) begin
                rx_byte <= {rx_hi, rx_nib};
            end
            if (rx_kind == RLC_SK_CTRL) begin
                rx_ctrl_sym <= rx_sym;
            end
        end
    end

    // ****************************************
    // held-high line reset detector
    // ****************************************
    logic [11:0] rst_cnt;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rst_cnt <= 12'h000;
            ring_rst_out <= 1'b0;
        end else if (ce) begin
            if (!dat_s) begin
                rst_cnt <= 12'h000;
                ring_rst_out <= 1'b0;
            end else begin
                if (rst_cnt != RST_HOLD) begin
                    rst_cnt <= rst_cnt + 12'h001;
                end
                ring_rst_out <= (rst_cnt >= RST_HOLD - 12'h001);
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_sof_seen;
        ce && rx_sof_hit;
    endsequence

    sequence s_hi_load;
        ce && tx_sym_end && u_out_if.valid
            && (tx_state == RLC_TX_K || tx_state == RLC_TX_LO);
    endsequence

    property p_sof_lock;
        s_sof_seen |=> rx_sof && rx_state == RLC_RX_FRAME;
    endproperty
    a_sof_lock: assert property (p_sof_lock)
        else $error("frame start pair not taken");

    property p_hi_first;
        s_hi_load |=> tx_state == RLC_TX_HI && tx_idx == 3'd0
            && tx_sym == rlc_enc($past(fifo_hi));
    endproperty
    a_hi_first: assert property (p_hi_first)
        else $error("upper nibble symbol not loaded");

    property p_nrzi;
        ce && clk_fall && !tx_force
            |=> (ring_dat_out ^ $past(ring_dat_out)) == $past(tx_bit);
    endproperty
    a_nrzi: assert property (p_nrzi)
        else $error("line level does not follow bit");

    property p_zero_run;
        tx_zrun <= 3'(`RLC_MAX_ZERO_RUN);
    endproperty
    a_zero_run: assert property (p_zero_run)
        else $error("too many zeros in a row");

    property p_regen;
        ce |=> ring_clk_out == $past(clk_s);
    endproperty
    a_regen: assert property (p_regen)
        else $error("clock not regenerated");

    property p_sample;
        ce && clk_rise |=> rx_win[0] == $past(rx_bit);
    endproperty
    a_sample: assert property (p_sample)
        else $error("bit not taken at clock rise");

    property p_code_err;
        ce && rx_sym_end && rx_kind == RLC_SK_BAD |=> rx_code_err && rx_state == RLC_RX_HUNT;
    endproperty
    a_code_err: assert property (p_code_err)
        else $error("bad symbol not flagged");

    property p_pair;
        ce && rx_sym_end && rx_kind == RLC_SK_DATA && rx_half
            |=> rx_byte_vld && rx_byte == {$past(rx_hi), $past(rx_nib)};
    endproperty
    a_pair: assert property (p_pair)
        else $error("nibbles paired in wrong order");

    property p_rst_det;
        ce && dat_s && rst_cnt == RST_HOLD - 12'h001 |=> ring_rst_out;
    endproperty
    a_rst_det: assert property (p_rst_det)
        else $error("held line did not raise reset");

    property p_rst_drop;
        ce && !dat_s |=> !ring_rst_out;
    endproperty
    a_rst_drop: assert property (p_rst_drop)
        else $error("reset stayed after line dropped");

endmodule : rlc_link_coder

`default_nettype wire

// ---- inc/rlc_map.svh ----
`ifndef RLC_MAP_SVH
`define RLC_MAP_SVH

// ****************************************
// symbol codes, leftmost table bit is bit 4
// ****************************************
`define RLC_SYM_IDLE 5'h1F
`define RLC_SYM_J 5'h18
`define RLC_SYM_K 5'h11
`define RLC_SYM_H 5'h04
`define RLC_SYM_R 5'h07
`define RLC_SYM_S 5'h19
`define RLC_SYM_T 5'h0D
// nibble n sits at bits [n*5 +: 5]
`define RLC_DATA_TABLE {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12, \
    5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E}
// J followed by K as ten received bits
`define RLC_SOF_PAIR 10'h311
`define RLC_MAX_ZERO_RUN 3

// ****************************************
// widths and timing
// ****************************************
`define RLC_BYTE_W 8
`define RLC_FIFO_DEPTH 4
`define RLC_MCLK_HZ 20000000
`define RLC_RST_HOLD_NS 10000
`define RLC_RST_HOLD_CYC ((`RLC_RST_HOLD_NS * (`RLC_MCLK_HZ / 1000000) + 999) / 1000)

`endif

// ---- inc/rlc_pkg.sv ----
`default_nettype none

package rlc_pkg;

    typedef enum logic [2:0] {
        RLC_TX_IDLE,
        RLC_TX_J,
        RLC_TX_K,
        RLC_TX_HI,
        RLC_TX_LO,
        RLC_TX_TERM
    } rlc_tx_state_t;

    typedef enum logic [0:0] {
        RLC_RX_HUNT,
        RLC_RX_FRAME
    } rlc_rx_state_t;

    typedef enum logic [1:0] {
        RLC_SK_DATA,
        RLC_SK_CTRL,
        RLC_SK_TERM,
        RLC_SK_BAD
    } rlc_sym_kind_t;

endpackage : rlc_pkg

`default_nettype wire

// ---- inc/rlc_strm_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface rlc_strm_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src(output data, output valid, input ready);
    modport snk(input data, input valid, output ready);
endinterface : rlc_strm_if

`default_nettype wire

// ---- core/rlc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rlc_sync #(
    parameter int W = 2
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] d_sync
);

    // ****************************************
    // two flops per pin, nothing reads meta
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta;
            logic q;
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    meta <= 1'b0;
                    q <= 1'b0;
                end else if (ce) begin
                    meta <= d_async[g];
                    q <= meta;
                end
            end
            assign d_sync[g] = q;
        end
    endgenerate

endmodule : rlc_sync

`default_nettype wire

// ---- core/rlc_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rlc_map.svh"

module rlc_fifo #(
    parameter int WIDTH = `RLC_BYTE_W,
    parameter int DEPTH = `RLC_FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    rlc_strm_if.snk wr,
    rlc_strm_if.src rd
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic do_wr;
    logic do_rd;

    assign wr.ready = (cnt != CW'(DEPTH));
    assign rd.valid = (cnt != '0);
    assign rd.data = mem[rp];
    assign do_wr = ce & wr.valid & wr.ready;
    assign do_rd = ce & rd.valid & rd.ready;

    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wp] <= wr.data;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wp <= '0;
        end else if (do_wr) begin
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rp <= '0;
        end else if (do_rd) begin
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (do_wr && !do_rd) begin
            cnt <= cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            cnt <= cnt - 1'b1;
        end
    end

endmodule : rlc_fifo

`default_nettype wire

// ---- tb/rlc_ring_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ********
// upstream ring master: free clock, NRZI data
// ********
module rlc_ring_model (
    output logic ring_clk_in,
    output logic ring_dat_in,
    input wire logic ring_clk_out,
    input wire logic ring_dat_out
);
    bit bq[$];
    logic force_hi = 1'b0;
    logic prev_o = 1'b0;
    logic [9:0] sh = '0;
    logic [14:0] cap = '0;
    int grab = 0;
    int n_cap = 0;
    int zrun = 0;
    int max_zero = 0;

    task automatic send(input logic [4:0] sym);
        for (int i = 4; i >= 0; i--) begin
            bq.push_back(sym[i]);
        end
    endtask : send

    // ring clock runs free at eight mclk periods, its edges 12 ns after an mclk rise
    initial begin
        ring_clk_in = 1'b0;
        ring_dat_in = 1'b0;
        #37;
        forever #200 ring_clk_in = ~ring_clk_in;
    end

    // data moves on the fall so it is settled at the rise
    always @(negedge ring_clk_in) begin
        if (force_hi) begin
            ring_dat_in <= 1'b1;
        end else if (bq.size() != 0) begin
            ring_dat_in <= ring_dat_in ^ bq.pop_front();
        end else begin
            ring_dat_in <= ~ring_dat_in;
        end
    end

    // ********
    // downstream side: decode the regenerated link
    // ********
    always @(posedge ring_clk_out) begin
        sh = {sh[8:0], ring_dat_out ^ prev_o};
        prev_o = ring_dat_out;
        zrun = sh[0] ? 0 : zrun + 1;
        if (zrun > max_zero) begin
            max_zero = zrun;
        end
        if (grab > 0) begin
            cap = {cap[13:0], sh[0]};
            grab--;
            if (grab == 0) begin
                n_cap++;
            end
        end else if (sh == 10'h311) begin
            grab = 15;
        end
    end
endmodule : rlc_ring_model

`default_nettype wire

// ---- tb/rlc_link_coder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module rlc_link_coder_tb;
    localparam logic [4:0] SYM [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
        5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    localparam logic [4:0] CTRL [4] = '{5'h1F, 5'h04, 5'h07, 5'h19};
    localparam logic [4:0] S_J = 5'h18;
    localparam logic [4:0] S_K = 5'h11;
    localparam logic [4:0] S_T = 5'h0D;
    localparam logic [7:0] ROWS [8] = '{8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hAB, 8'hCD, 8'hEF};
    logic mclk, sys_rst, ce, ring_clk_in, ring_dat_in, ring_clk_out, ring_dat_out;
    logic [1:0] held;
    logic tx_valid, tx_ready, tx_force_rst, rx_byte_vld, rx_sof, rx_eof, rx_ctrl;
    logic rx_code_err, ring_rst_out;
    logic [7:0] tx_data, rx_byte, last_byte;
    logic [4:0] rx_ctrl_sym;
    logic [4:0] ctrl_q[$];
    int n_errors = 0;
    int n_checks = 0;
    int n_byte, n_sof, n_eof, n_err, k, c0, nbad;

    rlc_link_coder rlc_link_coder_i (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .ring_clk_in(ring_clk_in), .ring_dat_in(ring_dat_in),
        .ring_clk_out(ring_clk_out), .ring_dat_out(ring_dat_out),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_force_rst(tx_force_rst), .rx_byte(rx_byte), .rx_byte_vld(rx_byte_vld),
        .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_ctrl(rx_ctrl), .rx_ctrl_sym(rx_ctrl_sym),
        .rx_code_err(rx_code_err), .ring_rst_out(ring_rst_out));

    rlc_ring_model rlc_ring_model_i (.ring_clk_in(ring_clk_in), .ring_dat_in(ring_dat_in),
        .ring_clk_out(ring_clk_out), .ring_dat_out(ring_dat_out));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // pulses last one cycle, so count them as they pass
    always @(posedge mclk) begin
        if (rx_byte_vld === 1'b1) begin
            n_byte++;
            last_byte = rx_byte;
        end
        if (rx_sof === 1'b1) n_sof++;
        if (rx_eof === 1'b1) n_eof++;
        if (rx_code_err === 1'b1) n_err++;
        if (rx_ctrl === 1'b1) ctrl_q.push_back(rx_ctrl_sym);
    end

    // ********
    // checks and handshakes
    // ********
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test

    task chk_v(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_v

    task chk_n(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_n

    task limit(input int lim);
        if (k >= lim) begin
            n_errors++;
            $display("timeout at %0t", $time);
            finish_test();
        end
    endtask : limit

    // leaves tx_valid high so back-to-back bytes need no gap
    task put(input logic [7:0] b);
        tx_data = b;
        tx_valid = 1'b1;
        for (k = 0; k < 2000 && tx_ready !== 1'b1; k++) begin
            @(posedge mclk);
            #2;
        end
        limit(2000);
        @(posedge mclk);
        #2;
    endtask : put

    task settle;
        for (k = 0; k < 3000 && rlc_ring_model_i.bq.size() != 0; k++) @(posedge mclk);
        limit(3000);
        repeat (40) @(posedge mclk);
        #2;
    endtask : settle

    task clr;
        n_byte = 0;
        n_sof = 0;
        n_eof = 0;
        n_err = 0;
        ctrl_q.delete();
        c0 = rlc_ring_model_i.n_cap;
    endtask : clr

    task wait_cap;
        for (k = 0; k < 3000 && rlc_ring_model_i.n_cap == c0; k++) @(posedge mclk);
        limit(3000);
        #2;
    endtask : wait_cap

    initial begin
        #2_000_000;
        n_errors++;
        $display("timeout at %0t", $time);
        finish_test();
    end

    // ********
    // main sequence
    // ********
    initial begin
        sys_rst = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        tx_force_rst = 1'b0;
        ce = 1'b1;
        clr();
        repeat (4) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        chk_v({tx_ready, rx_byte_vld, rx_sof, rx_eof, rx_ctrl, rx_code_err, ring_rst_out},
            16'h0040);
        chk_v({rx_byte, rx_ctrl_sym}, 16'h0000);
        $display("test reset done");
        for (int r = 0; r < 8; r++) begin
            clr();
            put(ROWS[r]);
            tx_valid = 1'b0;
            rlc_ring_model_i.send(S_J);
            rlc_ring_model_i.send(S_K);
            rlc_ring_model_i.send(SYM[ROWS[r][7:4]]);
            rlc_ring_model_i.send(SYM[ROWS[r][3:0]]);
            rlc_ring_model_i.send(S_T);
            wait_cap();
            settle();
            chk_n(n_sof, 1);
            chk_n(n_byte, 1);
            chk_n(n_eof, 1);
            chk_v(last_byte, ROWS[r]);
            chk_v(rlc_ring_model_i.cap, {SYM[ROWS[r][7:4]], SYM[ROWS[r][3:0]], S_T});
        end
        $display("test rows done");
        clr();
        rlc_ring_model_i.send(S_J);
        rlc_ring_model_i.send(S_K);
        for (int i = 0; i < 4; i++) rlc_ring_model_i.send(CTRL[i]);
        rlc_ring_model_i.send(S_T);
        settle();
        chk_n(ctrl_q.size(), 4);
        for (int i = 0; i < 4; i++) chk_v(ctrl_q[i], CTRL[i]);
        chk_n(n_eof + n_sof, 2);
        $display("test control done");
        clr();
        rlc_ring_model_i.send(S_J);
        rlc_ring_model_i.send(S_K);
        rlc_ring_model_i.send(SYM[3]);
        rlc_ring_model_i.send(5'h01);
        rlc_ring_model_i.send(S_T);
        settle();
        chk_n(n_err, 1);
        chk_n(n_byte + n_eof, 0);
        $display("test error done");
        clr();
        rlc_ring_model_i.max_zero = 0;
        put(8'h3C);
        put(8'hA5);
        put(8'h0F);
        put(8'h96);
        chk_v(tx_ready, 1'b0);
        put(8'h5A);
        tx_valid = 1'b0;
        wait_cap();
        chk_v(rlc_ring_model_i.cap, {SYM[3], SYM[12], SYM[10]});
        repeat (800) @(posedge mclk);
        #2;
        chk_n(rlc_ring_model_i.max_zero > 3, 0);
        $display("test fifo done");
        tx_force_rst = 1'b1;
        nbad = 0;
        for (k = 0; k < 40; k++) begin
            @(posedge mclk);
            #2;
            if (k > 4 && ring_dat_out !== 1'b1) nbad++;
        end
        chk_n(nbad, 0);
        tx_force_rst = 1'b0;
        rlc_ring_model_i.force_hi = 1'b1;
        repeat (150) @(posedge mclk);
        #2;
        chk_v(ring_rst_out, 1'b0);
        for (k = 0; k < 200 && ring_rst_out !== 1'b1; k++) begin
            @(posedge mclk);
            #2;
        end
        limit(200);
        @(posedge mclk);
        #2;
        chk_v(ring_dat_out, 1'b1);
        rlc_ring_model_i.force_hi = 1'b0;
        for (k = 0; k < 100 && ring_rst_out !== 1'b0; k++) begin
            @(posedge mclk);
            #2;
        end
        limit(100);
        $display("test ring reset done");
        // link outputs must freeze while enable is low
        ce = 1'b0;
        held = {ring_clk_out, ring_dat_out};
        repeat (20) @(posedge mclk);
        #2;
        chk_v({ring_clk_out, ring_dat_out}, held);
        ce = 1'b1;
        $display("test clock enable done");
        // a queued byte is flushed by reset and never framed
        clr();
        put(8'h11);
        tx_valid = 1'b0;
        sys_rst = 1'b1;
        repeat (4) @(posedge mclk);
        #2;
        sys_rst = 1'b0;
        chk_v({tx_ready, rx_byte_vld, rx_sof, rx_eof, rx_ctrl, rx_code_err, ring_rst_out},
            16'h0040);
        repeat (300) @(posedge mclk);
        #2;
        chk_n(rlc_ring_model_i.n_cap, c0);
        $display("test mid reset done");
        finish_test();
    end
endmodule : rlc_link_coder_tb

`default_nettype wire
